// ==== core/position_error_monitor.sv ====
// Position error monitor with gear selection, thresholds and alarm.
// Notes on behaviour
// - Gear select high picks second gear pair.
// - Second numerator 1..65535, resets to 32768.
// - Second denominator 1..65535, resets to 32768.
// - Second gear writes only while servo off.
// - Complete output when error magnitude within width.
// - Approach output when error within approach width.
// - Overflow alarm when error exceeds allowed limit.
// - Indicator line 1 follows complete only.
// - Widths affect outputs only, never positioning.
// - Outputs only in position mode, via pins.
`timescale 1ns/1ps
`include "posmon_cfg.svh"
module position_error_monitor
   import posmon_pkg::*;
#(
   parameter int ERR_W = 32
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic gear_select,
   input wire logic cmd_pulse,
   input wire logic cmd_dir,
   input wire logic fb_pulse,
   input wire logic fb_dir,
   output logic position_complete_out,
   output logic position_approach_out,
   output logic position_error_overflow_alarm,
   output logic status_led_line1,
   output logic irq
);
   gear_pair_t gear1_q, gear1_d;
   gear_pair_t gear2_q, gear2_d;
   // Staged second gear values wait for the apply bit.
   gear_pair_t gear2_stage_q, gear2_stage_d;
   logic [15:0] comp_w_q, comp_w_d;
   logic [15:0] appr_w_q, appr_w_d;
   logic [15:0] limit_q, limit_d;
   logic servo_on_q, servo_on_d;
   logic pos_mode_q, pos_mode_d;
   logic clear_q, clear_d;
   logic [2:0] irq_st_q, irq_st_d;
   logic [2:0] irq_en_q, irq_en_d;
   logic [15:0] rdata_d;
   logic signed [ERR_W-1:0] err_q, err_d;
   logic [ERR_W-1:0] err_abs;
   mon_flags_t flags_q, flags_d;
   logic led_d;
   logic irq_d;
   gear_pair_t ratio;
   logic step;
   logic step_dir;

   // Gear selection is a plain mux on the select level.
   // gear pair select
   assign ratio = gear_select ? gear2_q : gear1_q;

   gear_scaler u_gear (
      .clk(clk),
      .srst(srst),
      .clear(clear_q),
      .cmd_pulse(cmd_pulse),
      .cmd_dir(cmd_dir),
      .ratio(ratio),
      .step(step),
      .step_dir(step_dir)
   );

   function automatic logic [15:0] clamp_gear(input logic [15:0] v);
      clamp_gear = (v < `GEAR_MIN) ? `GEAR_MIN : v;
   endfunction

   function automatic logic [15:0] clamp_width(input logic [15:0] v);
      clamp_width = (v > `WIDTH_MAX) ? `WIDTH_MAX : v;
   endfunction

   // Register file.
   always_comb begin
      gear1_d = gear1_q;
      gear2_d = gear2_q;
      gear2_stage_d = gear2_stage_q;
      comp_w_d = comp_w_q;
      appr_w_d = appr_w_q;
      limit_d = limit_q;
      servo_on_d = servo_on_q;
      pos_mode_d = pos_mode_q;
      clear_d = 1'b0;
      irq_en_d = irq_en_q;
      if (reg_wr) begin
         unique case (reg_addr)
            `ADDR_GEAR1_NUM: gear1_d.num = clamp_gear(reg_wdata);
            `ADDR_GEAR1_DEN: gear1_d.den = clamp_gear(reg_wdata);
            `ADDR_GEAR2_NUM: begin
               if (!servo_on_q) begin
                  gear2_stage_d.num = clamp_gear(reg_wdata);
               end
            end
            `ADDR_GEAR2_DEN: begin
               if (!servo_on_q) begin
                  gear2_stage_d.den = clamp_gear(reg_wdata);
               end
            end
            `ADDR_COMP_WIDTH: comp_w_d = clamp_width(reg_wdata);
            `ADDR_APPR_WIDTH: appr_w_d = clamp_width(reg_wdata);
            `ADDR_ERR_LIMIT: limit_d = reg_wdata;
            `ADDR_CONTROL: begin
               servo_on_d = reg_wdata[`CTRL_SERVO_ON];
               pos_mode_d = reg_wdata[`CTRL_POS_MODE];
               clear_d = reg_wdata[`CTRL_CLEAR];
               if (reg_wdata[`CTRL_APPLY] && !servo_on_q) begin
                  gear2_d = gear2_stage_q;
               end
            end
            `ADDR_IRQ_ENABLE: irq_en_d = reg_wdata[2:0];
            default: begin
            end
         endcase
      end
   end

   // Read path; unmapped addresses read zero.
   always_comb begin
      rdata_d = 16'h0000;
      if (reg_rd) begin
         unique case (reg_addr)
            `ADDR_GEAR1_NUM: rdata_d = gear1_q.num;
            `ADDR_GEAR1_DEN: rdata_d = gear1_q.den;
            `ADDR_GEAR2_NUM: rdata_d = gear2_q.num;
            `ADDR_GEAR2_DEN: rdata_d = gear2_q.den;
            `ADDR_COMP_WIDTH: rdata_d = comp_w_q;
            `ADDR_APPR_WIDTH: rdata_d = appr_w_q;
            `ADDR_ERR_LIMIT: rdata_d = limit_q;
            `ADDR_CONTROL: rdata_d = {14'h0000, pos_mode_q, servo_on_q};
            `ADDR_STATUS: rdata_d = {13'h0000, flags_q};
            `ADDR_IRQ_STATUS: rdata_d = {13'h0000, irq_st_q};
            `ADDR_IRQ_ENABLE: rdata_d = {13'h0000, irq_en_q};
            `ADDR_ERROR: rdata_d = err_q[15:0];
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   // Error counter and comparators.
   always_comb begin
      err_d = err_q;
      if (clear_q) begin
         err_d = '0;
      end else if (step && !fb_pulse) begin
         err_d = step_dir ? err_q - ERR_W'(1) : err_q + ERR_W'(1);
      end else if (!step && fb_pulse) begin
         err_d = fb_dir ? err_q + ERR_W'(1) : err_q - ERR_W'(1);
      end else if (step && fb_pulse && (step_dir != fb_dir)) begin
         err_d = step_dir ? err_q - ERR_W'(2) : err_q + ERR_W'(2);
      end
   end

   assign err_abs = err_q[ERR_W-1] ? ERR_W'(-err_q) : ERR_W'(err_q);

   // Widths only gate flag outputs; the servo loop never reads them.
   // widths gate flags only
   always_comb begin
      flags_d.complete = pos_mode_q &&
         (err_abs <= {{(ERR_W-16){1'b0}}, comp_w_q});
      flags_d.approach = pos_mode_q &&
         (err_abs <= {{(ERR_W-16){1'b0}}, appr_w_q});
      flags_d.overflow = pos_mode_q &&
         (err_abs > {{(ERR_W-16){1'b0}}, limit_q});
      led_d = flags_d.complete;
   end

   // Sticky rising-edge events; a new event beats a same-cycle clear.
   always_comb begin
      irq_st_d = irq_st_q;
      if (reg_wr && reg_addr == `ADDR_IRQ_CLEAR) begin
         irq_st_d = irq_st_q & ~reg_wdata[2:0];
      end
      irq_st_d = irq_st_d | (flags_d & ~flags_q);
      irq_d = |(irq_st_d & irq_en_d);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         gear1_q <= {`GEAR_RESET, `GEAR_RESET};
         gear2_q <= {`GEAR_RESET, `GEAR_RESET};
         gear2_stage_q <= {`GEAR_RESET, `GEAR_RESET};
         comp_w_q <= `COMP_WIDTH_RESET;
         appr_w_q <= `APPR_WIDTH_RESET;
         limit_q <= `ERR_LIMIT_RESET;
         servo_on_q <= 1'b0;
         pos_mode_q <= 1'b1;
         clear_q <= 1'b0;
         irq_st_q <= 3'h0;
         irq_en_q <= 3'h0;
         reg_rdata <= 16'h0000;
         err_q <= '0;
         flags_q <= '0;
         position_complete_out <= 1'b0;
         position_approach_out <= 1'b0;
         position_error_overflow_alarm <= 1'b0;
         status_led_line1 <= 1'b0;
         irq <= 1'b0;
      end else begin
         gear1_q <= gear1_d;
         gear2_q <= gear2_d;
         gear2_stage_q <= gear2_stage_d;
         comp_w_q <= comp_w_d;
         appr_w_q <= appr_w_d;
         limit_q <= limit_d;
         servo_on_q <= servo_on_d;
         pos_mode_q <= pos_mode_d;
         clear_q <= clear_d;
         irq_st_q <= irq_st_d;
         irq_en_q <= irq_en_d;
         reg_rdata <= rdata_d;
         err_q <= err_d;
         flags_q <= flags_d;
         position_complete_out <= flags_d.complete;
         position_approach_out <= flags_d.approach;
         position_error_overflow_alarm <= flags_d.overflow;
         status_led_line1 <= led_d;
         irq <= irq_d;
      end
   end

   chk_gear2_locked: assert property (
      @(posedge clk) disable iff (srst)
      servo_on_q |=> $stable(gear2_q))
      else $error("second gear changed while servo on");
   chk_led_follows: assert property (
      @(posedge clk) disable iff (srst)
      status_led_line1 == position_complete_out)
      else $error("indicator differs from complete output");
   chk_complete_width: assert property (
      @(posedge clk) disable iff (srst)
      flags_q.complete |-> err_abs <= {{(ERR_W-16){1'b0}}, comp_w_q}
         || $changed(err_q) || $changed(comp_w_q))
      else $error("complete set outside width");
   chk_complete_off: assert property (
      @(posedge clk) disable iff (srst)
      (err_abs > {{(ERR_W-16){1'b0}}, comp_w_q})
      |=> !position_complete_out)
      else $error("complete set beyond width");
   chk_approach_on: assert property (
      @(posedge clk) disable iff (srst)
      (pos_mode_q && err_abs <= {{(ERR_W-16){1'b0}}, appr_w_q})
      |=> position_approach_out)
      else $error("approach missing within width");
   chk_approach_off: assert property (
      @(posedge clk) disable iff (srst)
      (err_abs > {{(ERR_W-16){1'b0}}, appr_w_q})
      |=> !position_approach_out)
      else $error("approach set beyond width");
   chk_width_max: assert property (
      @(posedge clk) disable iff (srst)
      comp_w_q <= `WIDTH_MAX && appr_w_q <= `WIDTH_MAX)
      else $error("width above its maximum");
   chk_overflow_on: assert property (
      @(posedge clk) disable iff (srst)
      (pos_mode_q && err_abs > {{(ERR_W-16){1'b0}}, limit_q})
      |=> position_error_overflow_alarm)
      else $error("overflow alarm missing");
   chk_overflow_off: assert property (
      @(posedge clk) disable iff (srst)
      (err_abs <= {{(ERR_W-16){1'b0}}, limit_q})
      |=> !position_error_overflow_alarm)
      else $error("overflow alarm within limit");
   chk_mode_gate: assert property (
      @(posedge clk) disable iff (srst)
      !pos_mode_q |=> !position_complete_out && !position_approach_out)
      else $error("outputs active outside position mode");
   chk_gear_select: assert property (
      @(posedge clk) disable iff (srst)
      ratio == (gear_select ? gear2_q : gear1_q))
      else $error("wrong gear pair selected");
   chk_gear_min: assert property (
      @(posedge clk) disable iff (srst)
      gear2_q.num != 16'h0000 && gear2_q.den != 16'h0000)
      else $error("second gear value zero");
   chk_error_clear: assert property (
      @(posedge clk) disable iff (srst)
      clear_q |=> err_q == '0)
      else $error("error count not cleared");
endmodule

// ==== core/posmon_cfg.svh ====
// Constants for the position error monitor.
`ifndef POSMON_CFG_SVH
`define POSMON_CFG_SVH
`define ADDR_GEAR1_NUM 4'h0
`define ADDR_GEAR1_DEN 4'h1
`define ADDR_GEAR2_NUM 4'h2
`define ADDR_GEAR2_DEN 4'h3
`define ADDR_COMP_WIDTH 4'h4
`define ADDR_APPR_WIDTH 4'h5
`define ADDR_ERR_LIMIT 4'h6
`define ADDR_CONTROL 4'h7
`define ADDR_STATUS 4'h8
`define ADDR_IRQ_STATUS 4'h9
`define ADDR_IRQ_ENABLE 4'hA
`define ADDR_IRQ_CLEAR 4'hB
`define ADDR_ERROR 4'hC
`define GEAR_RESET 16'h8000
`define GEAR_MIN 16'h0001
`define COMP_WIDTH_RESET 16'h000A
`define APPR_WIDTH_RESET 16'h0014
`define WIDTH_MAX 16'h03E8
`define ERR_LIMIT_RESET 16'h5000
`define CTRL_SERVO_ON 0
`define CTRL_POS_MODE 1
`define CTRL_APPLY 2
`define CTRL_CLEAR 3
`define IRQ_COMPLETE 0
`define IRQ_APPROACH 1
`define IRQ_OVERFLOW 2
`endif

// ==== core/posmon_pkg.sv ====
// Types shared by the position error monitor files.
package posmon_pkg;
   typedef struct packed {
      logic [15:0] num;
      logic [15:0] den;
   } gear_pair_t;
   // Complete sits in bit 0 so the status and interrupt layouts line up.
   typedef struct packed {
      logic overflow;
      logic approach;
      logic complete;
   } mon_flags_t;
endpackage

// ==== core/gear_scaler.sv ====
// Electronic gear: scales command pulses by numerator over denominator.
`timescale 1ns/1ps
module gear_scaler
   import posmon_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic clear,
   input wire logic cmd_pulse,
   input wire logic cmd_dir,
   input gear_pair_t ratio,
   output logic step,
   output logic step_dir
);
   // Steps bring the remainder back below den; a pulse adds num only when the remainder is below den and clear is low, emitted steps subtract.
   logic [32:0] rem_q, rem_d;
   logic dir_q, dir_d;
   logic step_d;

   always_comb begin
      rem_d = rem_q;
      dir_d = dir_q;
      step_d = 1'b0;
      if (clear) begin
         rem_d = 33'h0_0000_0000;
      end else if (rem_q >= {17'h0_0000, ratio.den}) begin
         // One step per cycle; the accumulator drains before more input.
         rem_d = rem_q - {17'h0_0000, ratio.den};
         step_d = 1'b1;
      end else if (cmd_pulse) begin
         rem_d = rem_q + {17'h0_0000, ratio.num};
         dir_d = cmd_dir;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rem_q <= 33'h0_0000_0000;
         dir_q <= 1'b0;
         step <= 1'b0;
         step_dir <= 1'b0;
      end else begin
         rem_q <= rem_d;
         dir_q <= dir_d;
         step <= step_d;
         step_dir <= dir_q;
      end
   end
endmodule

// ==== test/host_pulse_model.sv ====
// Host controller model that issues command and feedback pulses.
`timescale 1ns/1ps
module host_pulse_model (
   input wire logic clk,
   output logic cmd_pulse,
   output logic cmd_dir,
   output logic fb_pulse,
   output logic fb_dir
);
   initial begin
      cmd_pulse = 1'b0;
      cmd_dir = 1'b1;
      fb_pulse = 1'b0;
      fb_dir = 1'b1;
   end
   // Direction means nothing between pulses, so it shows the inverse there.
   // Pulses are spaced five cycles so the gear scaler has drained each one.
   task automatic send(input logic fb, input logic dir, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         if (fb) begin
            fb_pulse <= 1'b1;
            fb_dir <= dir;
         end else begin
            cmd_pulse <= 1'b1;
            cmd_dir <= dir;
         end
         @(posedge clk);
         fb_pulse <= 1'b0;
         cmd_pulse <= 1'b0;
         fb_dir <= ~dir;
         cmd_dir <= ~dir;
         repeat (3) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask
endmodule

// ==== test/test_position_error_monitor.sv ====
// Self-checking bench for the position error monitor.
`timescale 1ns/1ps
`include "posmon_cfg.svh"
`define CHK(got, exp) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("Error at %0t: got %0h expected %0h", $time, got, exp); \
      end \
   end
module test_position_error_monitor;
   logic clk, srst, reg_wr, reg_rd, gear_select, irq, led;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic cp, cd, fp, fd, comp, appr, ovf;
   int failures = 0;
   int n_checks = 0;
   logic [15:0] rst_vals [7] = '{16'h8000, 16'h8000, 16'h8000, 16'h8000,
      16'h000A, 16'h0014, 16'h5000};

   position_error_monitor #(.ERR_W(32)) dut (.clk(clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gear_select(gear_select),
      .cmd_pulse(cp), .cmd_dir(cd), .fb_pulse(fp), .fb_dir(fd),
      .position_complete_out(comp), .position_approach_out(appr),
      .position_error_overflow_alarm(ovf), .status_led_line1(led),
      .irq(irq));
   host_pulse_model host (.clk(clk), .cmd_pulse(cp), .cmd_dir(cd),
      .fb_pulse(fp), .fb_dir(fd));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask

   // Expected bits are overflow, approach, complete; the lamp copies complete.
   task automatic flags(input logic [2:0] e);
      #1;
      `CHK({led, ovf, appr, comp}, {e[0], e})
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      #750000;
      failures++;
      close_out();
   end

   initial begin
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      gear_select = 1'b0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         rd(i[3:0], d);
         `CHK(d, rst_vals[i])
      end
      flags(3'b011);
      rd(`ADDR_IRQ_STATUS, d);
      `CHK(d[0], 1'b1)
      `CHK(d[1], 1'b1)
      `CHK(irq, 1'b0)
      rd(`ADDR_STATUS, d);
      `CHK(d, 16'h0003)
      wr(`ADDR_IRQ_ENABLE, 16'h0001);
      repeat (2) @(posedge clk);
      #1 `CHK(irq, 1'b1)
      wr(`ADDR_IRQ_CLEAR, 16'h0001);
      repeat (2) @(posedge clk);
      #1 `CHK(irq, 1'b0)
      $display("reset and interrupt test done");
      wr(4'h0, 16'h0001);
      wr(4'h1, 16'h0001);
      wr(4'h4, 16'h0002);
      wr(4'h5, 16'h0004);
      wr(4'h6, 16'h0006);
      wr(`ADDR_CONTROL, 16'h000A);
      host.send(1'b0, 1'b0, 3);
      flags(3'b010);
      rd(`ADDR_ERROR, d);
      `CHK(d, 16'h0003)
      host.send(1'b0, 1'b0, 2);
      flags(3'b000);
      wr(`ADDR_IRQ_ENABLE, 16'h0004);
      host.send(1'b0, 1'b0, 2);
      flags(3'b100);
      `CHK(irq, 1'b1)
      wr(`ADDR_IRQ_CLEAR, 16'h0004);
      repeat (2) @(posedge clk);
      #1 `CHK(irq, 1'b0)
      // feedback brings approach back before complete
      host.send(1'b1, 1'b0, 3);
      flags(3'b010);
      host.send(1'b1, 1'b0, 2);
      flags(3'b011);
      $display("threshold test done");
      wr(4'h4, 16'h07D0);
      rd(4'h4, d);
      `CHK(d, 16'h03E8)
      wr(`ADDR_CONTROL, 16'h0003);
      wr(4'h2, 16'h0005);
      wr(`ADDR_CONTROL, 16'h0007);
      rd(4'h2, d);
      `CHK(d, 16'h8000)
      // gear changes only with the servo off
      wr(`ADDR_CONTROL, 16'h0002);
      wr(4'h2, 16'h0002);
      wr(4'h3, 16'h0000);
      wr(`ADDR_CONTROL, 16'h0006);
      rd(4'h2, d);
      `CHK(d, 16'h0002)
      rd(4'h3, d);
      `CHK(d, 16'h0001)
      $display("gear setting test done");
      @(posedge clk);
      gear_select <= 1'b1;
      wr(`ADDR_CONTROL, 16'h000A);
      host.send(1'b0, 1'b0, 1);
      rd(`ADDR_ERROR, d);
      `CHK(d, 16'h0002)
      @(posedge clk);
      gear_select <= 1'b0;
      host.send(1'b0, 1'b0, 1);
      rd(`ADDR_ERROR, d);
      `CHK(d, 16'h0003)
      wr(`ADDR_CONTROL, 16'h0000);
      repeat (3) @(posedge clk);
      flags(3'b000);
      rd(4'hD, d);
      `CHK(d, 16'h0000)
      $display("gear select and mode test done");
      close_out();
   end
endmodule
